// ==== hw/tic_top.sv ====
// Terminal input conditioning: run decode, up/down, analog and pulse
// Operation
// - Command method 0..3 selects two- or three-wire decoding, default 0.
// - Two-wire 1: first switch forward, second reverse, both or none stop.
// - Two-wire 2: forward enables run, reverse level picks direction.
// - Three-wire 1: forward/reverse pulse starts run while stop enable closed.
// - Three-wire 1: run stays latched until stop enable opens.
// - Three-wire 2: forward pulse runs, reverse level gives direction.
// - Three-wire 2: stop enable open stops regardless of other inputs.
// - Up/down terminals ramp set frequency at configured rate per second.
// - Decimal setting scales rate step: 0.001 or 0.01 Hz/s.
// - Input above curve maximum is clamped to maximum.
// - Below minimum gives minimum setting or 0.0% by per-input digit.
// - Current input: 1 mA counts as 0.5 V.
// - Each analog input is low-pass filtered, 0 to 10 s constant.
// - Curve three accepts bipolar inputs down to -10 V.
// - Pulse frequency only on input 5, mapped linearly, max 100 kHz.
// - Ones digit picks curve for input 1, tens digit for input 2.
// - Inputs 1 to 3 delay state changes by 0 to 3600 s.
// - Active level select inverts valid sense per input.
`timescale 1ns/1ps
module tic_top #(
  parameter int TICK_CYCLES = tic_pkg::TICK_CYCLES
) (
  input  wire logic                i_ref_clk,
  input  wire logic                i_rst_b,
  input  wire logic [5:0]          i_di_pin,
  input  wire logic [5:0]          i_input_active_level_select,
  input  wire logic [15:0]         i_input_one_delay,
  input  wire logic [15:0]         i_input_two_delay,
  input  wire logic [15:0]         i_input_three_delay,
  input  wire logic [1:0]          i_terminal_command_method,
  input  wire logic [15:0]         i_updown_change_rate,
  input  wire logic [1:0]          i_frequency_decimal_setting,
  input  wire logic [15:0]         i_freq_limit,
  input  wire logic signed [15:0]  i_analog_input_one,
  input  wire logic signed [15:0]  i_analog_input_two,
  input  wire logic [1:0]          i_current_mode,
  input  wire logic [15:0]         i_ai1_filter_tc,
  input  wire logic [15:0]         i_ai2_filter_tc,
  input  wire logic [15:0]         i_pulse_filter_tc,
  input  wire logic [11:0]         i_analog_curve_select,
  input  wire logic [7:0]          i_below_minimum_select,
  input  wire logic signed [15:0]  i_curve_min_in [3],
  input  wire logic signed [15:0]  i_curve_min_set [3],
  input  wire logic signed [15:0]  i_curve_max_in [3],
  input  wire logic signed [15:0]  i_curve_max_set [3],
  input  wire logic signed [15:0]  i_pulse_min_in,
  input  wire logic signed [15:0]  i_pulse_min_set,
  input  wire logic signed [15:0]  i_pulse_max_in,
  input  wire logic signed [15:0]  i_pulse_max_set,
  output logic                     o_run,
  output logic                     o_reverse,
  output logic [5:0]               o_di_state,
  output logic [15:0]              o_set_freq,
  output logic signed [15:0]       o_ai1_setting,
  output logic signed [15:0]       o_ai2_setting,
  output logic [15:0]              o_pulse_freq,
  output logic signed [15:0]       o_pulse_setting
);
  localparam int NDI = tic_pkg::NUM_DI;

  // Digit 1..3 picks a curve; anything else falls back to curve one
  function automatic logic [1:0] curve_index(input logic [3:0] digit);
    if (digit >= tic_pkg::CURVE_ONE && digit <= tic_pkg::CURVE_THREE) begin
      curve_index = 2'(digit - tic_pkg::CURVE_ONE);
    end else begin
      curve_index = 2'h0;
    end
  endfunction

  // Millisecond time base
  logic [17:0] tick_cnt_reg;
  logic        tick_reg;
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      tick_cnt_reg <= 18'h00000;
      tick_reg     <= 1'b0;
    end else if (tick_cnt_reg == 18'(TICK_CYCLES - 1)) begin
      tick_cnt_reg <= 18'h00000;
      tick_reg     <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 18'h00001;
      tick_reg     <= 1'b0;
    end
  end

  // Pin synchronisers
  logic [NDI-1:0] meta_reg;
  logic [NDI-1:0] sync_reg;
  logic [NDI-1:0] valid;
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= i_di_pin;
      sync_reg <= meta_reg;
    end
  end
  // Pin high means contact closed to common
  assign valid = sync_reg ^ i_input_active_level_select;

  // Per-input delay on the first three inputs
  logic [15:0]    delay_cfg [tic_pkg::NUM_DELAYED];
  logic [NDI-1:0] state_reg;
  assign delay_cfg[0] = i_input_one_delay;
  assign delay_cfg[1] = i_input_two_delay;
  assign delay_cfg[2] = i_input_three_delay;

  genvar g;
  generate
    for (g = 0; g < NDI; g++) begin : g_di
      if (g < tic_pkg::NUM_DELAYED) begin : g_dly
        // Counts in ms; a bounce back resets the wait
        logic [21:0] cnt_reg;
        logic [21:0] target;
        assign target = 22'(32'(delay_cfg[g]) * tic_pkg::DELAY_UNIT_MS);
        always_ff @(posedge i_ref_clk) begin
          if (!i_rst_b) begin
            cnt_reg      <= 22'h000000;
            state_reg[g] <= 1'b0;
          end else if (valid[g] == state_reg[g]) begin
            cnt_reg <= 22'h000000;
          end else if (cnt_reg >= target) begin
            state_reg[g] <= valid[g];
            cnt_reg      <= 22'h000000;
          end else if (tick_reg) begin
            cnt_reg <= cnt_reg + 22'h000001;
          end
        end
      end else begin : g_nodly
        always_ff @(posedge i_ref_clk) begin
          if (!i_rst_b) begin
            state_reg[g] <= 1'b0;
          end else begin
            state_reg[g] <= valid[g];
          end
        end
      end
    end
  endgenerate
  assign o_di_state = state_reg;

  // Run command decoding
  logic     forward_input;
  logic     reverse_input;
  logic     stop_en;
  logic     fwd_d_reg;
  logic     rev_d_reg;
  logic     fwd_rise;
  logic     rev_rise;
  tic_pkg::tic_run_t run_reg;
  tic_pkg::tic_run_t run_next;
  assign forward_input      = state_reg[tic_pkg::DI_FWD];
  assign reverse_input      = state_reg[tic_pkg::DI_REV];
  assign stop_en  = state_reg[tic_pkg::DI_STOP];
  assign fwd_rise = forward_input && !fwd_d_reg;
  assign rev_rise = reverse_input && !rev_d_reg;

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      fwd_d_reg <= 1'b0;
      rev_d_reg <= 1'b0;
    end else begin
      fwd_d_reg <= forward_input;
      rev_d_reg <= reverse_input;
    end
  end

  always_comb begin
    run_next = run_reg;
    case (i_terminal_command_method)
      tic_pkg::MODE_TWO_WIRE_1: begin
        if (forward_input && !reverse_input) begin
          run_next = tic_pkg::TIC_FWD;
        end else if (reverse_input && !forward_input) begin
          run_next = tic_pkg::TIC_REV;
        end else begin
          run_next = tic_pkg::TIC_STOP;
        end
      end
      tic_pkg::MODE_TWO_WIRE_2: begin
        if (!forward_input) begin
          run_next = tic_pkg::TIC_STOP;
        end else if (reverse_input) begin
          run_next = tic_pkg::TIC_REV;
        end else begin
          run_next = tic_pkg::TIC_FWD;
        end
      end
      tic_pkg::MODE_THREE_WIRE_1: begin
        if (!stop_en) begin
          run_next = tic_pkg::TIC_STOP;
        end else if (fwd_rise) begin
          run_next = tic_pkg::TIC_FWD;
        end else if (rev_rise) begin
          run_next = tic_pkg::TIC_REV;
        end
      end
      default: begin
        if (!stop_en) begin
          run_next = tic_pkg::TIC_STOP;
        end else if (fwd_rise || run_reg != tic_pkg::TIC_STOP) begin
          // Direction follows the reverse level while running
          run_next = reverse_input ? tic_pkg::TIC_REV : tic_pkg::TIC_FWD;
        end
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      run_reg   <= tic_pkg::TIC_STOP;
      o_run     <= 1'b0;
      o_reverse <= 1'b0;
    end else begin
      run_reg   <= run_next;
      o_run     <= run_next != tic_pkg::TIC_STOP;
      o_reverse <= run_next == tic_pkg::TIC_REV;
    end
  end

  // Up/down ramp. Rate is added each ms; one LSB of o_set_freq is
  // 10000 rate units per ms for both decimal settings, so the decimal
  // setting only changes what one unit means.
  logic        up;
  logic        down;
  logic [16:0] frac_reg;
  assign up   = state_reg[tic_pkg::DI_UP];
  assign down = state_reg[tic_pkg::DI_DOWN];

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      frac_reg   <= 17'h00000;
      o_set_freq <= tic_pkg::FREQ_RESET;
    end else if (up == down) begin
      frac_reg <= 17'h00000;
    end else if (tick_reg) begin
      frac_reg <= frac_reg + 17'(i_updown_change_rate);
    end else if (frac_reg >= 17'(tic_pkg::UPDOWN_FRAC_ONE)) begin
      frac_reg <= frac_reg - 17'(tic_pkg::UPDOWN_FRAC_ONE);
      if (up && o_set_freq < i_freq_limit) begin
        o_set_freq <= o_set_freq + 16'h0001;
      end else if (down && o_set_freq != 16'h0000) begin
        o_set_freq <= o_set_freq - 16'h0001;
      end
    end
  end

  // Analog front end; current input given in uA, halved to mV
  logic signed [15:0] ai_mv [2];
  logic signed [15:0] ai_flt [2];
  logic signed [15:0] ai_set [2];
  logic [1:0]         ai_curve [2];
  assign ai_mv[0] = i_current_mode[0] ? (i_analog_input_one >>> 1)
                                      : i_analog_input_one;
  assign ai_mv[1] = i_current_mode[1] ? (i_analog_input_two >>> 1)
                                      : i_analog_input_two;
  assign ai_curve[0] = curve_index(i_analog_curve_select[3:0]);
  assign ai_curve[1] = curve_index(i_analog_curve_select[7:4]);

  tic_lpf u_lpf_ai1 (
    .i_ref_clk (i_ref_clk),
    .i_rst_b   (i_rst_b),
    .i_tick    (tick_reg),
    .i_tc      (i_ai1_filter_tc),
    .i_x       (ai_mv[0]),
    .o_y       (ai_flt[0])
  );

  tic_lpf u_lpf_ai2 (
    .i_ref_clk (i_ref_clk),
    .i_rst_b   (i_rst_b),
    .i_tick    (tick_reg),
    .i_tc      (i_ai2_filter_tc),
    .i_x       (ai_mv[1]),
    .o_y       (ai_flt[1])
  );

  // Curve three bounds are signed, so bipolar inputs pass unchanged
  generate
    for (g = 0; g < 2; g++) begin : g_ai
      tic_curve u_curve (
        .i_x          (ai_flt[g]),
        .i_min_in     (i_curve_min_in[ai_curve[g]]),
        .i_max_in     (i_curve_max_in[ai_curve[g]]),
        .i_min_set    (i_curve_min_set[ai_curve[g]]),
        .i_max_set    (i_curve_max_set[ai_curve[g]]),
        .i_below_zero (i_below_minimum_select[4*g]),
        .o_y          (ai_set[g])
      );
    end
  endgenerate

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_ai1_setting <= 16'sh0000;
      o_ai2_setting <= 16'sh0000;
    end else begin
      o_ai1_setting <= ai_set[0];
      o_ai2_setting <= ai_set[1];
    end
  end

  // Pulse frequency: edges over 100 ms give 10 Hz units directly
  logic       pulse_d_reg;
  logic [15:0] edge_cnt_reg;
  logic [6:0] gate_cnt_reg;
  logic signed [15:0] pulse_flt;
  logic signed [15:0] pulse_set;
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      pulse_d_reg  <= 1'b0;
      edge_cnt_reg <= 16'h0000;
      gate_cnt_reg <= 7'h00;
      o_pulse_freq <= 16'h0000;
    end else begin
      pulse_d_reg <= state_reg[tic_pkg::DI_PULSE];
      if (tick_reg && gate_cnt_reg == 7'(tic_pkg::PULSE_GATE_MS - 1)) begin
        gate_cnt_reg <= 7'h00;
        o_pulse_freq <= edge_cnt_reg;
        edge_cnt_reg <= 16'h0000;
      end else begin
        if (tick_reg) begin
          gate_cnt_reg <= gate_cnt_reg + 7'h01;
        end
        if (state_reg[tic_pkg::DI_PULSE] && !pulse_d_reg) begin
          edge_cnt_reg <= edge_cnt_reg + 16'h0001;
        end
      end
    end
  end

  tic_lpf u_lpf_pulse (
    .i_ref_clk (i_ref_clk),
    .i_rst_b   (i_rst_b),
    .i_tick    (tick_reg),
    .i_tc      (i_pulse_filter_tc),
    .i_x       (o_pulse_freq),
    .o_y       (pulse_flt)
  );

  tic_curve u_curve_pulse (
    .i_x          (pulse_flt),
    .i_min_in     (i_pulse_min_in),
    .i_max_in     (i_pulse_max_in),
    .i_min_set    (i_pulse_min_set),
    .i_max_set    (i_pulse_max_set),
    .i_below_zero (1'b0),
    .o_y          (pulse_set)
  );

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_pulse_setting <= 16'sh0000;
    end else begin
      o_pulse_setting <= pulse_set;
    end
  end
endmodule

// ==== hw/tic_pkg.sv ====
// Shared constants for terminal input conditioning
package tic_pkg;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int TICK_TIME_US  = 1000;
  localparam int TICK_CYCLES   = TICK_TIME_US * 1000 / (CLK_PERIOD_PS / 1000);
  localparam int DELAY_UNIT_MS  = 100;
  localparam int FILTER_UNIT_MS = 10;
  localparam int PULSE_GATE_MS  = 100;
  localparam int UPDOWN_FRAC_ONE = 10000;
  localparam int NUM_DI      = 6;
  localparam int NUM_DELAYED = 3;
  localparam int DI_FWD   = 0;
  localparam int DI_REV   = 1;
  localparam int DI_STOP  = 2;
  localparam int DI_UP    = 3;
  localparam int DI_PULSE = 4;
  localparam int DI_DOWN  = 5;
  localparam logic [1:0] MODE_TWO_WIRE_1   = 2'h0;
  localparam logic [1:0] MODE_TWO_WIRE_2   = 2'h1;
  localparam logic [1:0] MODE_THREE_WIRE_1 = 2'h2;
  localparam logic [1:0] MODE_THREE_WIRE_2 = 2'h3;
  localparam logic [1:0] CMD_METHOD_RESET  = 2'h0;
  localparam logic [3:0] CURVE_ONE   = 4'h1;
  localparam logic [3:0] CURVE_THREE = 4'h3;
  localparam logic [15:0] FREQ_RESET = 16'h0000;
  typedef enum {TIC_STOP, TIC_FWD, TIC_REV} tic_run_t;
endpackage

// ==== hw/tic_curve.sv ====
// Two-point curve: clamp, below-minimum handling, interpolation
`timescale 1ns/1ps
module tic_curve (
  input  wire logic signed [15:0] i_x,
  input  wire logic signed [15:0] i_min_in,
  input  wire logic signed [15:0] i_max_in,
  input  wire logic signed [15:0] i_min_set,
  input  wire logic signed [15:0] i_max_set,
  input  wire logic               i_below_zero,
  output logic signed [15:0]      o_y
);
  logic signed [15:0] xc;
  logic signed [39:0] num;
  logic signed [39:0] den;
  logic signed [39:0] q;
  always_comb begin
    xc  = (i_x > i_max_in) ? i_max_in : i_x;
    den = 40'(i_max_in) - 40'(i_min_in);
    num = (40'(xc) - 40'(i_min_in)) * (40'(i_max_set) - 40'(i_min_set));
    q   = 40'sh0;
    if (i_x < i_min_in) begin
      o_y = i_below_zero ? 16'sh0000 : i_min_set;
    end else if (den <= 40'sh0) begin
      o_y = i_max_set;
    end else begin
      q   = num / den;
      o_y = 16'(40'(i_min_set) + q);
    end
  end
endmodule

// ==== hw/tic_lpf.sv ====
// First-order low-pass with time constant in 10 ms steps
`timescale 1ns/1ps
module tic_lpf (
  input  wire logic               i_ref_clk,
  input  wire logic               i_rst_b,
  input  wire logic               i_tick,
  input  wire logic [15:0]        i_tc,
  input  wire logic signed [15:0] i_x,
  output logic signed [15:0]      o_y
);
  // Steps of one LSB are spread over the millisecond, so no divider
  logic signed [15:0] y_reg;
  logic signed [31:0] err_reg;
  logic signed [31:0] n;
  assign n   = 32'(i_tc) * 32'(tic_pkg::FILTER_UNIT_MS);
  assign o_y = y_reg;
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      y_reg   <= 16'sh0000;
      err_reg <= 32'sh0;
    end else if (i_tc == 16'h0000) begin
      y_reg   <= i_x;
      err_reg <= 32'sh0;
    end else if (i_tick) begin
      err_reg <= err_reg + 32'(i_x) - 32'(y_reg);
    end else if (err_reg >= n) begin
      y_reg   <= y_reg + 16'sh0001;
      err_reg <= err_reg - n;
    end else if (err_reg <= -n) begin
      y_reg   <= y_reg - 16'sh0001;
      err_reg <= err_reg + n;
    end
  end
endmodule

// ==== bench/tic_top_assertions.sv ====
// Checker for run decoding, terminal levels and up/down stepping
`timescale 1ns/1ps
module tic_top_checker (
  input wire logic        i_ref_clk,
  input wire logic        i_rst_b,
  input wire logic [5:0]  i_di_pin,
  input wire logic [5:0]  i_input_active_level_select,
  input wire logic [1:0]  i_terminal_command_method,
  input wire logic        o_run,
  input wire logic        o_reverse,
  input wire logic [5:0]  o_di_state,
  input wire logic [15:0] o_set_freq
);
  logic [2:0] up_cnt_reg;
  logic       ok;
  // Pipeline still holds reset values for a few edges after release
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) up_cnt_reg <= 3'h0;
    else if (up_cnt_reg != 3'h7) up_cnt_reg <= up_cnt_reg + 3'h1;
  end
  assign ok = (up_cnt_reg >= 3'h5);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  property p_level;
    ok && $past(i_input_active_level_select, 3) == i_input_active_level_select |->
      o_di_state[5:3] == $past(i_di_pin[5:3] ^ i_input_active_level_select[5:3], 3);
  endproperty
  a_level: assert property (p_level) else $error("terminal level wrong");
  property p_two1;
    ok && $past(i_terminal_command_method) == 2'h0 |->
      o_run == ($past(o_di_state[0]) ^ $past(o_di_state[1])) &&
      o_reverse == ($past(o_di_state[1]) && !$past(o_di_state[0]));
  endproperty
  a_two1: assert property (p_two1) else $error("two-wire 1 decode wrong");
  property p_two2;
    ok && $past(i_terminal_command_method) == 2'h1 |->
      o_run == $past(o_di_state[0]) &&
      o_reverse == ($past(o_di_state[0]) && $past(o_di_state[1]));
  endproperty
  a_two2: assert property (p_two2) else $error("two-wire 2 decode wrong");
  property p_start1;
    ok && $past(i_terminal_command_method) == 2'h2 && $past(o_di_state[2]) &&
      $past(o_di_state[0]) && !$past(o_di_state[0], 2) |-> o_run && !o_reverse;
  endproperty
  a_start1: assert property (p_start1) else $error("forward start missed");
  property p_stop1;
    ok && $past(i_terminal_command_method) == 2'h2 && !$past(o_di_state[2]) |-> !o_run;
  endproperty
  a_stop1: assert property (p_stop1) else $error("three-wire 1 stop missed");
  property p_stop2;
    ok && $past(i_terminal_command_method) == 2'h3 && !$past(o_di_state[2]) |-> !o_run;
  endproperty
  a_stop2: assert property (p_stop2) else $error("three-wire 2 stop missed");
  property p_dir2;
    ok && $past(i_terminal_command_method) == 2'h3 && o_run |->
      o_reverse == $past(o_di_state[1]);
  endproperty
  a_dir2: assert property (p_dir2) else $error("three-wire 2 direction wrong");
  property p_step;
    ok && o_set_freq != $past(o_set_freq) |->
      (o_set_freq - $past(o_set_freq) == 16'h1) || ($past(o_set_freq) - o_set_freq == 16'h1);
  endproperty
  a_step: assert property (p_step) else $error("set frequency jumped");
  property p_rev;
    o_reverse |-> o_run;
  endproperty
  a_rev: assert property (p_rev) else $error("reverse while stopped");
  c_run1: cover property (i_terminal_command_method == 2'h2 && o_run);
  c_rev2: cover property (i_terminal_command_method == 2'h3 && o_reverse);
  c_up: cover property (ok && o_set_freq > $past(o_set_freq));
endmodule

// ==== bench/tic_contacts.sv ====
// Contacts, buttons and pulse source on the terminal side
`timescale 1ns/1ps
module tic_contacts (
  input  wire logic       i_ref_clk,
  input  wire logic [5:0] i_closed,
  input  wire logic [7:0] i_period,
  output logic      [5:0] o_di_pin
);
  logic [7:0] cnt_reg = 8'h0;
  logic       pulse_reg = 1'b0;
  // Pulse train only on the pulse capable input
  always_ff @(posedge i_ref_clk) begin
    if (i_period == 8'h0 || cnt_reg >= i_period - 8'h1) cnt_reg <= 8'h0;
    else cnt_reg <= cnt_reg + 8'h1;
    pulse_reg <= (i_period != 8'h0) && (cnt_reg < {1'b0, i_period[7:1]});
  end
  // Stop enable contact is bit 2, the three-wire control terminal
  assign o_di_pin = {i_closed[5], i_closed[4] | pulse_reg, i_closed[3:0]};
endmodule

// ==== bench/test_tic_top.sv ====
// Self-checking bench for terminal input conditioning
`timescale 1ns/1ps
module test_tic_top;
  logic               i_ref_clk = 1'b0;
  logic               i_rst_b = 1'b0;
  logic [5:0]         cl = 6'h0, sel = 6'h0, pin, st;
  logic [7:0]         per = 8'h0, bsel = 8'h0;
  logic [15:0]        dly = 16'h0, rate = 16'h0, lim = 16'h5, tc1 = 16'h0, sf, pf;
  logic [1:0]         mode = 2'h0, cur = 2'h0, dec = 2'h2;
  logic [11:0]        csel = 12'h031;
  logic signed [15:0] a1 = 16'sh0, a2 = -16'sd5000, s1, s2, ps;
  logic signed [15:0] cmi [3], cms [3], cxi [3], cxs [3];
  logic               run, reverse_input;
  int                 errors = 0, checked = 0;
  tic_contacts u_sw (.i_ref_clk(i_ref_clk), .i_closed(cl), .i_period(per), .o_di_pin(pin));
  tic_top #(.TICK_CYCLES(20)) dut (
    .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_di_pin(pin),
    .i_input_active_level_select(sel), .i_input_one_delay(dly),
    .i_input_two_delay(dly), .i_input_three_delay(dly),
    .i_terminal_command_method(mode), .i_updown_change_rate(rate),
    .i_frequency_decimal_setting(dec), .i_freq_limit(lim),
    .i_analog_input_one(a1), .i_analog_input_two(a2), .i_current_mode(cur),
    .i_ai1_filter_tc(tc1), .i_ai2_filter_tc(16'h0), .i_pulse_filter_tc(16'h0),
    .i_analog_curve_select(csel), .i_below_minimum_select(bsel),
    .i_curve_min_in(cmi), .i_curve_min_set(cms), .i_curve_max_in(cxi),
    .i_curve_max_set(cxs), .i_pulse_min_in(16'sh0), .i_pulse_min_set(cms[0]),
    .i_pulse_max_in(16'sd100), .i_pulse_max_set(cxs[0]), .o_run(run),
    .o_reverse(reverse_input), .o_di_state(st), .o_set_freq(sf), .o_ai1_setting(s1),
    .o_ai2_setting(s2), .o_pulse_freq(pf), .o_pulse_setting(ps));
  initial begin
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask
  task automatic sw(input logic [5:0] c, input int w);
    @(posedge i_ref_clk);
    cl <= c;
    cyc(w);
  endtask
  task automatic runchk(input logic r, input logic v);
    chk("run", {15'h0, r}, {15'h0, run});
    chk("rev", {15'h0, v}, {15'h0, reverse_input});
  endtask
  task automatic ana(input logic signed [15:0] x, input logic [1:0] c, input logic [7:0] b,
                     input logic [15:0] e);
    @(posedge i_ref_clk);
    a1 <= x;
    cur <= c;
    bsel <= b;
    cyc(100);
    chk("ai1", e, s1);
  endtask
  task automatic close_out;
    if (errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    for (int i = 0; i < 3; i++) begin
      cmi[i] = 16'sd1000;
      cms[i] = 16'sd1000;
      cxi[i] = 16'sd9000;
      cxs[i] = 16'sd10000;
    end
    cmi[2] = -16'sd10000;
    cms[2] = -16'sd10000;
    cxi[2] = 16'sd10000;
    cyc(4);
    i_rst_b <= 1'b1;
    cyc(2);
    runchk(1'b0, 1'b0);
    for (int m = 0; m < 2; m++) begin
      mode <= m[1:0];
      for (int k = 0; k < 4; k++) begin
        sw({4'h0, k[1:0]}, 8);
        runchk(m ? k[0] : k[0] ^ k[1], m ? k[0] & k[1] : k == 2);
      end
    end
    mode <= 2'h2;
    sw(6'h04, 8);
    sw(6'h05, 8);
    sw(6'h04, 8);
    runchk(1'b1, 1'b0);
    sw(6'h06, 8);
    sw(6'h04, 8);
    runchk(1'b1, 1'b1);
    sw(6'h00, 8);
    runchk(1'b0, 1'b0);
    mode <= 2'h3;
    sw(6'h06, 8);
    sw(6'h07, 8);
    sw(6'h06, 8);
    runchk(1'b1, 1'b1);
    sw(6'h04, 8);
    runchk(1'b1, 1'b0);
    sw(6'h03, 8);
    runchk(1'b0, 1'b0);
    mode <= 2'h0;
    rate <= 16'd10000;
    sel <= 6'h08;
    sw(6'h00, 400);
    chk("st", 16'h8, {10'h0, st});
    chk("cap", 16'h5, sf);
    sel <= 6'h00;
    sw(6'h20, 400);
    chk("floor", 16'h0, sf);
    lim <= 16'hffff;
    rate <= 16'd2000;
    sw(6'h08, 1000);
    chk("rate", 16'h1, {15'h0, sf >= 16'd9 && sf <= 16'd11});
    dly <= 16'h1;
    sw(6'h01, 1900);
    chk("early", 16'h0, {15'h0, st[0]});
    cyc(200);
    chk("late", 16'h1, {15'h0, st[0]});
    sw(6'h00, 1000);
    chk("hold", 16'h1, {15'h0, st[0]});
    sw(6'h01, 1500);
    chk("glitch", 16'h1, {15'h0, st[0]});
    // A bounce must restart the wait, so a fresh release needs the full delay
    sw(6'h00, 1100);
    chk("rearm", 16'h1, {15'h0, st[0]});
    ana(16'sd5000, 2'h0, 8'h0, 16'sd5500);
    ana(16'sd9500, 2'h0, 8'h0, 16'sd10000);
    ana(16'sd500, 2'h0, 8'h0, 16'sd1000);
    ana(16'sd500, 2'h0, 8'h1, 16'sh0);
    ana(16'sd10000, 2'h1, 8'h0, 16'sd5500);
    chk("ai2", -16'sd5000, s2);
    ana(16'sd9000, 2'h0, 8'h0, 16'sd10000);
    // Short sim tick leaves 19 steps per ms, so keep the slope under that
    tc1 <= 16'd20;
    a1 <= 16'sd6000;
    cyc(1000);
    chk("lag", 16'h1, {15'h0, s1 > 16'sd7750});
    cyc(16000);
    chk("lpf", 16'h1, {15'h0, s1 >= 16'sd6625 && s1 < 16'sd6800});
    per <= 8'd40;
    cyc(6000);
    chk("pf", 16'h1, {15'h0, pf >= 16'd49 && pf <= 16'd51});
    chk("ps", 16'h1, {15'h0, ps >= 16'sd5400 && ps <= 16'sd5600});
    close_out();
  end
  initial begin
    #300us;
    errors++;
    close_out();
  end
endmodule
bind tic_top tic_top_checker u_chk (
  .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_di_pin(i_di_pin),
  .i_input_active_level_select(i_input_active_level_select),
  .i_terminal_command_method(i_terminal_command_method), .o_run(o_run),
  .o_reverse(o_reverse), .o_di_state(o_di_state), .o_set_freq(o_set_freq));
